// [include/siel_params.svh]
// holds the bit positions, reset values and sizes of the interrupt/error block
// assumes a single inclusion point per compilation unit
`ifndef SIEL_PARAMS_SVH
`define SIEL_PARAMS_SVH

// ****************************************
// status word layout
// ****************************************
`define SIEL_ST_W        16
`define SIEL_ST_IRQ      0
`define SIEL_ST_UNDERRUN 4
`define SIEL_ST_TX       5
`define SIEL_ST_RX       6
`define SIEL_ST_OVERFLOW 7
`define SIEL_ST_SELECT_RELEASE_ERROR    12
`define SIEL_ST_RESET    16'h0000

// ****************************************
// serial side
// ****************************************
`define SIEL_BYTE_W      8
`define SIEL_FIFO_DEPTH  8
`define SIEL_BIT_RESET   3'h7
`define SIEL_BIT_LAST    3'h0
`define SIEL_BIT_STEP    3'h1
`define SIEL_PIN_W       4
`define SIEL_PIN_IDLE    4'h2
`define SIEL_PIN_CLK     0
`define SIEL_PIN_SEL     1
`define SIEL_PIN_MOSI    2
`define SIEL_PIN_MISO    3
`define SIEL_SHIFT_IDLE  8'hff
`define SIEL_CNT_W       4
`define SIEL_CNT_ONE     4'h1
`define SIEL_CNT_ZERO    4'h0

`endif

// [include/siel_pkg.sv]
// holds the types shared by the interrupt/error block and its bench
// assumes siel_params.svh sits on the include path
package siel_pkg;
  typedef enum logic [1:0] {
    FRAME_IDLE    = 2'b00,
    FRAME_ACTIVE  = 2'b01,
    FRAME_STALLED = 2'b10
  } siel_frame_t;
  typedef logic [7:0] siel_byte_t;
  typedef logic [1:0] siel_thresh_t;
endpackage

// [verilog/siel_fifo.sv]
// holds the receive byte fifo: parameterised width and depth, valid/ready both sides
// assumes one clock domain and a synchronous flush from the owner
module siel_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   flush,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  output logic [$clog2(D+1)-1:0]      level
);
  localparam int PW = $clog2(D);
  localparam int LW = $clog2(D+1);

  logic [W-1:0]  mem [D];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic          push;
  logic          pop;

  assign in_ready  = (level != LW'(D));
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    return (p == PW'(D - 1)) ? '0 : p + PW'(1);
  endfunction

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wrap_inc(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= wrap_inc(rd_ptr);
      end
      if (push && !pop) begin
        level <= level + LW'(1);
      end else if (pop && !push) begin
        level <= level - LW'(1);
      end
    end
  end
endmodule // siel_fifo

// [verilog/siel_core.sv]
// holds the interrupt, error and open-drain output logic of the serial port
// assumes clock line and select pins arrive asynchronously; control bits are static levels
`include "siel_params.svh"

// Overview of operation
// - five source flags plus combined interrupt state appear in the status word
// - direction select picks transmit (set) or receive (clear) interrupt
// - select-release error always raises the interrupt
// - master: byte interrupts follow the last clock edge of each byte
// - slave: byte interrupts at next byte's first edge or select release
// - transmit interrupt counts loaded bytes: every 1, 2, 3 or 4
// - configuration write zeroes the transmitted-byte counter
// - transmit flag in bit 5, cleared by status read, masked by its disable
// - receive flag in bit 6, evaluated only when a byte enters the fifo
// - receive interrupt compares fifo fill against the threshold
// - after a status read, receive fires again only on a new byte
// - receive disable suppresses the receive interrupt
// - transfer starting with empty transmit side sets underrun, bit 4
// - byte arriving at a full fifo sets overflow and interrupts unless receive disable is set
// - flags clear on status read and on disable; transmit and receive flags also on their flush
// - open-drain mode drives the data line only for zero bits
// - bit counter wraps after eight clocks, holds across select release unless its reset enable is set
// - select release with bit counter not at 7 sets the error flag
module siel_core (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 enable,
  input  wire logic                 master_mode,
  input  wire logic                 irq_direction_select,
  input  wire siel_pkg::siel_thresh_t irq_threshold,
  input  wire logic                 tx_irq_disable,
  input  wire logic                 rx_irq_disable,
  input  wire logic                 tx_flush,
  input  wire logic                 rx_flush,
  input  wire logic                 config_write,
  input  wire logic                 status_read,
  input  wire logic                 bit_counter_reset_enable,
  input  wire logic                 open_drain_output_mode,
  input  wire logic                 serial_clock_line,
  input  wire logic                 select_n,
  input  wire logic                 mosi_in,
  input  wire logic                 miso_in,
  output logic                      mosi_out,
  output logic                      mosi_oe_n,
  output logic                      miso_out,
  output logic                      miso_oe_n,
  input  wire siel_pkg::siel_byte_t tx_data,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  output siel_pkg::siel_byte_t      rx_data,
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic [`SIEL_ST_W-1:0]     serial_status_reg,
  output logic                      irq
);
  import siel_pkg::*;

  logic [`SIEL_PIN_W-1:0] sync1;
  logic [`SIEL_PIN_W-1:0] sync2;
  logic [`SIEL_PIN_W-1:0] sync3;
  logic [`SIEL_PIN_W-1:0] pin_f;
  logic [`SIEL_PIN_W-1:0] pin_q;
  logic                   clk_rise;
  logic                   clk_fall;
  logic                   cs_fall;
  logic                   cs_rise;
  logic                   cs_low;
  logic                   serial_in;
  logic [2:0]             bit_cnt;
  siel_frame_t            frame;
  siel_byte_t             rx_shift;
  siel_byte_t             rx_hold;
  siel_byte_t             new_byte;
  logic                   byte_done;
  logic                   byte_pend;
  logic                   byte_evt;
  siel_byte_t             push_data;
  logic                   fifo_in_ready;
  logic [`SIEL_CNT_W-1:0] rx_level;
  siel_byte_t             tx_hold;
  logic                   tx_hold_valid;
  logic                   next_hold_valid;
  siel_byte_t             tx_shift;
  logic                   load_evt;
  logic                   tx_accept;
  logic [`SIEL_CNT_W-1:0] tx_count;
  logic [`SIEL_CNT_W-1:0] next_tx_count;
  logic                   start_evt;
  logic                   underrun_flag;
  logic                   tx_flag;
  logic                   rx_flag;
  logic                   overflow_flag;
  logic                   select_release_error;
  logic                   set_underrun;
  logic                   set_tx;
  logic                   set_rx;
  logic                   set_overflow;
  logic                   set_select_release_error;
  logic                   next_irq;
  logic                   drive_active;

  // count reached once it passes the threshold code
  function automatic logic siel_reached(input logic [`SIEL_CNT_W-1:0] cnt,
                                        input siel_thresh_t          th);
    return cnt > {2'b00, th};
  endfunction

  // ****************************************
  // pin sampling
  // ****************************************
  // a change is taken only once the second and third stages agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1 <= `SIEL_PIN_IDLE;
      sync2 <= `SIEL_PIN_IDLE;
      sync3 <= `SIEL_PIN_IDLE;
      pin_f <= `SIEL_PIN_IDLE;
      pin_q <= `SIEL_PIN_IDLE;
    end else begin
      sync1 <= {miso_in, mosi_in, select_n, serial_clock_line};
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < `SIEL_PIN_W; i++) begin
        if (sync2[i] == sync3[i]) begin
          pin_f[i] <= sync2[i];
        end
      end
      pin_q <= pin_f;
    end
  end

  assign cs_low    = ~pin_f[`SIEL_PIN_SEL];
  assign clk_rise  = pin_f[`SIEL_PIN_CLK] & ~pin_q[`SIEL_PIN_CLK] & cs_low & enable;
  assign clk_fall  = ~pin_f[`SIEL_PIN_CLK] & pin_q[`SIEL_PIN_CLK] & cs_low & enable;
  assign cs_fall   = ~pin_f[`SIEL_PIN_SEL] & pin_q[`SIEL_PIN_SEL] & enable;
  assign cs_rise   = pin_f[`SIEL_PIN_SEL] & ~pin_q[`SIEL_PIN_SEL] & enable;
  assign serial_in = master_mode ? pin_f[`SIEL_PIN_MISO] : pin_f[`SIEL_PIN_MOSI];

  // ****************************************
  // bit counter and framing
  // ****************************************
  assign byte_done = clk_rise & (bit_cnt == `SIEL_BIT_LAST);
  assign new_byte  = {rx_shift[6:0], serial_in};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= `SIEL_BIT_RESET;
    end else if (!enable) begin
      bit_cnt <= `SIEL_BIT_RESET;
    end else if (clk_rise) begin
      bit_cnt <= byte_done ? `SIEL_BIT_RESET : bit_cnt - `SIEL_BIT_STEP;
    end else if (cs_rise && bit_counter_reset_enable) begin
      bit_cnt <= `SIEL_BIT_RESET;
    end
  end

  // a mid-byte release with counter reset off leaves the frame stalled, to resume
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame <= FRAME_IDLE;
    end else if (!enable) begin
      frame <= FRAME_IDLE;
    end else begin
      case (frame)
        FRAME_IDLE:    frame <= cs_fall ? FRAME_ACTIVE : FRAME_IDLE;
        FRAME_ACTIVE: begin
          if (cs_rise) begin
            frame <= (bit_cnt != `SIEL_BIT_RESET && !bit_counter_reset_enable)
                     ? FRAME_STALLED : FRAME_IDLE;
          end
        end
        FRAME_STALLED: frame <= cs_fall ? FRAME_ACTIVE : FRAME_STALLED;
        default:       frame <= FRAME_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_shift <= '0;
    end else if (clk_rise) begin
      rx_shift <= new_byte;
    end
  end

  // ****************************************
  // byte event timing per mode
  // ****************************************
  // slave defers the event so a late release still reports the byte
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      byte_pend <= 1'b0;
      rx_hold   <= '0;
    end else if (!enable) begin
      byte_pend <= 1'b0;
    end else if (byte_done && !master_mode) begin
      byte_pend <= 1'b1;
      rx_hold   <= new_byte;
    end else if (byte_evt) begin
      byte_pend <= 1'b0;
    end
  end

  assign byte_evt  = master_mode ? byte_done
                                 : byte_pend & (clk_rise | cs_rise);
  assign push_data = master_mode ? new_byte : rx_hold;

  siel_fifo #(
    .W (`SIEL_BYTE_W),
    .D (`SIEL_FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .flush     (rx_flush | ~enable),
    .in_valid  (byte_evt),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data),
    .level     (rx_level)
  );

  // ****************************************
  // transmit holding and shifting
  // ****************************************
  assign start_evt       = cs_fall & (frame == FRAME_IDLE);
  assign load_evt        = start_evt | (byte_done & cs_low);
  assign tx_accept       = tx_valid & tx_ready;
  assign next_hold_valid = ~tx_flush & enable &
                           (tx_accept | (tx_hold_valid & ~load_evt));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_hold_valid <= 1'b0;
      tx_ready      <= 1'b0;
      tx_hold       <= '0;
    end else begin
      tx_hold_valid <= next_hold_valid;
      tx_ready      <= ~next_hold_valid & enable;
      if (tx_accept) begin
        tx_hold <= tx_data;
      end
    end
  end

  // an empty load keeps the old byte; the shift engine rotates it, it never zero-fills
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_shift <= `SIEL_SHIFT_IDLE;
    end else if (load_evt && tx_hold_valid) begin
      tx_shift <= tx_hold;
    end else if (clk_fall) begin
      tx_shift <= {tx_shift[6:0], tx_shift[7]};
    end
  end

  assign next_tx_count = tx_count + `SIEL_CNT_ONE;
  assign set_tx        = load_evt & tx_hold_valid & siel_reached(next_tx_count, irq_threshold);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_count <= `SIEL_CNT_ZERO;
    end else if (config_write || !enable || set_tx) begin
      tx_count <= `SIEL_CNT_ZERO;
    end else if (load_evt && tx_hold_valid) begin
      tx_count <= next_tx_count;
    end
  end

  // ****************************************
  // source flags
  // ****************************************
  assign set_underrun = start_evt & ~tx_hold_valid;
  assign set_rx       = byte_evt & fifo_in_ready &
                        siel_reached(rx_level + `SIEL_CNT_ONE, irq_threshold);
  assign set_overflow = byte_evt & ~fifo_in_ready;
  assign set_select_release_error    = cs_rise & (bit_cnt != `SIEL_BIT_RESET);

  // set wins over a status read landing in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      underrun_flag        <= 1'b0;
      tx_flag              <= 1'b0;
      rx_flag              <= 1'b0;
      overflow_flag        <= 1'b0;
      select_release_error <= 1'b0;
    end else if (!enable) begin
      underrun_flag        <= 1'b0;
      tx_flag              <= 1'b0;
      rx_flag              <= 1'b0;
      overflow_flag        <= 1'b0;
      select_release_error <= 1'b0;
    end else begin
      underrun_flag        <= set_underrun | (underrun_flag & ~status_read);
      tx_flag              <= set_tx | (tx_flag & ~status_read & ~tx_flush);
      rx_flag              <= set_rx | (rx_flag & ~status_read & ~rx_flush);
      overflow_flag        <= set_overflow | (overflow_flag & ~status_read);
      select_release_error <= set_select_release_error | (select_release_error & ~status_read);
    end
  end

  // ****************************************
  // interrupt line and status word
  // ****************************************
  assign next_irq = select_release_error
                  | (tx_flag & irq_direction_select & ~tx_irq_disable)
                  | (rx_flag & ~irq_direction_select & ~rx_irq_disable)
                  | (underrun_flag & ~tx_irq_disable)
                  | (overflow_flag & ~rx_irq_disable);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq               <= 1'b0;
      serial_status_reg <= `SIEL_ST_RESET;
    end else begin
      irq                                   <= next_irq;
      serial_status_reg                     <= `SIEL_ST_RESET;
      serial_status_reg[`SIEL_ST_IRQ]       <= next_irq;
      serial_status_reg[`SIEL_ST_UNDERRUN]  <= underrun_flag;
      serial_status_reg[`SIEL_ST_TX]        <= tx_flag;
      serial_status_reg[`SIEL_ST_RX]        <= rx_flag;
      serial_status_reg[`SIEL_ST_OVERFLOW]  <= overflow_flag;
      serial_status_reg[`SIEL_ST_SELECT_RELEASE_ERROR]     <= select_release_error;
    end
  end

  // ****************************************
  // data outputs
  // ****************************************
  // open-drain relies on an external pull-up to form the one level
  assign drive_active = enable & (master_mode | cs_low);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mosi_out  <= 1'b1;
      mosi_oe_n <= 1'b1;
      miso_out  <= 1'b1;
      miso_oe_n <= 1'b1;
    end else begin
      mosi_out  <= tx_shift[7];
      miso_out  <= tx_shift[7];
      mosi_oe_n <= ~(drive_active & master_mode &
                     (~open_drain_output_mode | ~tx_shift[7]));
      miso_oe_n <= ~(drive_active & ~master_mode &
                     (~open_drain_output_mode | ~tx_shift[7]));
    end
  end

  // ****************************************
  // checks
  // ****************************************
  select_release_error_set_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (set_select_release_error && enable) |=> select_release_error ##1 serial_status_reg[`SIEL_ST_SELECT_RELEASE_ERROR])
    else $error("release error not flagged");

  select_release_error_irq_a: assert property (
    @(posedge core_clk) disable iff (rst)
    select_release_error |=> irq)
    else $error("release error did not raise irq");

  rx_gate_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (tx_flag && !rx_flag && !underrun_flag && !overflow_flag && !select_release_error
     && !irq_direction_select) |=> !irq)
    else $error("transmit flag leaked in receive mode");

  disable_mask_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (tx_irq_disable && rx_irq_disable && !select_release_error) |=> !irq)
    else $error("disabled sources raised irq");

  read_clear_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (status_read && !set_tx && !set_rx && !set_underrun && !set_overflow && !set_select_release_error)
    |=> !(tx_flag || rx_flag || underrun_flag || overflow_flag || select_release_error))
    else $error("status read left a flag set");

  off_quiet_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !enable ##1 !enable |=> !irq && serial_status_reg == `SIEL_ST_RESET)
    else $error("irq active while disabled");

  count_hold_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (enable && !cs_low && !cs_rise) ##1 enable |-> $stable(bit_cnt))
    else $error("bit counter moved with select released");

  overflow_set_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (set_overflow && enable) |=> overflow_flag ##1 (irq || rx_irq_disable || !enable))
    else $error("overflow not reported");

  underrun_set_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (start_evt && !tx_hold_valid) |=> underrun_flag)
    else $error("underrun not flagged");

  wired_zero_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (!mosi_oe_n && $past(open_drain_output_mode)) |-> !mosi_out)
    else $error("open-drain line driven high");

  // slave side carries the open-drain traffic in the bench
  wired_zero_s_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (!miso_oe_n && $past(open_drain_output_mode)) |-> !miso_out)
    else $error("open-drain return line driven high");
endmodule // siel_core

// [test/siel_far_master.sv]
// far-side bus master: drives serial clock, select and data-in pins of the port
// assumes the bench core clock; one link half period is 10 core cycles (80 ns period)
module siel_far_master (
  input  wire logic core_clk,
  output logic      serial_clock_line,
  output logic      select_n,
  output logic      mosi_in,
  input  wire logic miso_wire
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    serial_clock_line = 1'b0;
    select_n          = 1'b1;
    mosi_in           = 1'b0;
  end

  task automatic half();
    repeat (10) @(posedge core_clk);
  endtask

  // clock stands still outside frames; data line flips once released
  task automatic xfer(input siel_pkg::siel_byte_t d, input int nbits,
                      output siel_pkg::siel_byte_t got);
    siel_pkg::siel_byte_t sh;
    begin
      sh = d;
      got = 8'h00;
      select_n <= 1'b0;
      mosi_in  <= sh[7];
      half();
      for (int i = 0; i < nbits; i++) begin
        serial_clock_line <= 1'b1;
        got = {got[6:0], miso_wire};
        half();
        serial_clock_line <= 1'b0;
        sh = sh << 1;
        mosi_in <= sh[7];
        half();
      end
      select_n <= 1'b1;
      mosi_in  <= ~mosi_in;
      half();
    end
  endtask
endmodule // siel_far_master

// [test/testbench.sv]
// self-checking bench: slave-mode port against a far-side master and an integer model
// assumes siel_pkg is compiled first and siel_params.svh is on the include path
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // stimulus and model state
  // ****************************************
  logic                   core_clk    = 1'b0;
  logic                   rst         = 1'b1;
  logic                   enable      = 1'b1;
  logic                   dir_sel     = 1'b0;
  logic                   tx_dis      = 1'b0;
  logic                   rx_dis      = 1'b0;
  logic                   rx_flush    = 1'b0;
  logic                   status_read = 1'b0;
  logic                   od_mode     = 1'b0;
  logic                   rx_ready    = 1'b0;
  logic                   tx_valid    = 1'b0;
  siel_pkg::siel_thresh_t th          = 2'h0;
  siel_pkg::siel_byte_t   tx_data     = 8'h00;
  siel_pkg::siel_byte_t   rx_data, got, d;
  logic                   sclk, sel_n, mosi, miso_out, miso_oe_n, tx_ready, rx_valid, irq;
  logic [15:0]            status;
  int                     seed        = 42;
  int                     err_total   = 0;
  int                     cmp_count   = 0;
  int                     fill        = 0;
  siel_pkg::siel_byte_t   exp_q[$];
  // open-drain line with external pull-up
  wire                    miso_wire   = miso_oe_n ? 1'b1 : miso_out;

  always #2 core_clk = ~core_clk;

  siel_core dut_u (.core_clk(core_clk), .rst(rst), .enable(enable), .master_mode(1'b0),
    .irq_direction_select(dir_sel), .irq_threshold(th), .tx_irq_disable(tx_dis),
    .rx_irq_disable(rx_dis), .tx_flush(1'b0), .rx_flush(rx_flush), .config_write(1'b0),
    .status_read(status_read), .bit_counter_reset_enable(1'b1),
    .open_drain_output_mode(od_mode), .serial_clock_line(sclk), .select_n(sel_n),
    .mosi_in(mosi), .miso_in(1'b0), .mosi_out(), .mosi_oe_n(), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .serial_status_reg(status), .irq(irq));

  siel_far_master far_u (.core_clk(core_clk), .serial_clock_line(sclk), .select_n(sel_n),
    .mosi_in(mosi), .miso_wire(miso_wire));

  // ****************************************
  // model and checks
  // ****************************************
  // flags always latch; only the line is gated by mode and disables
  function automatic logic [16:0] model(input bit u, t, r, o, c);
    logic q;
    begin
      q = (u & !tx_dis) | (t & dir_sel & !tx_dis) | (r & !dir_sel & !rx_dis) | (o & !rx_dis) | c;
      return {q, 3'b000, c, 4'h0, o, r, t, u, 3'b000, q};
    end
  endfunction

  task automatic cmp_status(input logic [15:0] mask, input logic [16:0] exp);
    cmp_count++;
    if ({irq, status & mask} !== (exp & {1'b1, mask})) begin
      err_total++;
      $display("FAIL t=%0t status act=%h exp=%h", $time, {irq, status}, exp);
    end
  endtask

  task automatic cmp_byte(input siel_pkg::siel_byte_t act, input siel_pkg::siel_byte_t exp);
    cmp_count++;
    if (act !== exp) begin
      err_total++;
      $display("FAIL t=%0t byte act=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic pulse_read();
    status_read <= 1'b1;
    @(posedge core_clk);
    status_read <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic shuffle();
    th      <= 2'($random(seed));
    dir_sel <= 1'($random(seed));
    tx_dis  <= 1'($random(seed));
    rx_dis  <= 1'($random(seed));
    @(posedge core_clk);
  endtask

  task automatic drain_one();
    rx_ready <= 1'b1;
    @(posedge core_clk);
    while (rx_valid !== 1'b1) @(posedge core_clk);
    cmp_byte(rx_data, exp_q.pop_front());
    rx_ready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    // empty hold every frame; fill runs past depth into overflow
    for (int n = 0; n < 10; n++) begin
      shuffle();
      d = 8'($random(seed));
      far_u.xfer(d, 8, got);
      repeat (10) @(posedge core_clk);
      if (fill == 8) begin
        cmp_status(16'hffff, model(1, 0, 0, 1, 0));
      end else begin
        fill++;
        exp_q.push_back(d);
        cmp_status(16'hffff, model(1, 0, fill > th, 0, 0));
      end
      pulse_read();
      cmp_status(16'hffff, model(0, 0, 0, 0, 0));
    end
    while (exp_q.size() > 0) drain_one();
    // held byte shifted out open-drain, threshold zero
    d = 8'($random(seed));
    od_mode <= 1'b1;
    th <= 2'h0;
    tx_data <= d;
    tx_valid <= 1'b1;
    @(posedge core_clk);
    while (tx_ready !== 1'b1) @(posedge core_clk);
    tx_valid <= 1'b0;
    far_u.xfer(~d, 8, got);
    repeat (10) @(posedge core_clk);
    cmp_byte(got, d);
    cmp_status(16'hffff, model(0, 1, 1, 0, 0));
    pulse_read();
    // mid-byte release, then recovery by enable toggle with select high
    far_u.xfer(d, 4, got);
    repeat (10) @(posedge core_clk);
    cmp_status(16'h1011, model(1, 0, 0, 0, 1));
    rx_flush <= 1'b1;
    enable <= 1'b0;
    repeat (2) @(posedge core_clk);
    rx_flush <= 1'b0;
    enable <= 1'b1;
    repeat (4) @(posedge core_clk);
    cmp_status(16'hffff, model(0, 0, 0, 0, 0));
    far_u.xfer(d, 8, got);
    repeat (10) @(posedge core_clk);
    cmp_status(16'hffff, model(1, 0, 1 > th, 0, 0));
    print_verdict();
  end

  // whole run is near 2500 cycles; allow four times that
  initial begin
    #40000;
    err_total++;
    print_verdict();
  end
endmodule // testbench
